// *** tccfg_map.vh ***
// Register map, field layout, encodings and timing constants of the CC config block
`ifndef TCCFG_MAP_VH
`define TCCFG_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TCCFG_REG_VERSION   8'h01
`define TCCFG_REG_CTRL      8'h02
`define TCCFG_REG_INT_AD    8'h03
`define TCCFG_REG_CC_STAT   8'h04
`define TCCFG_REG_CONDET    8'h09
`define TCCFG_REG_VCONN     8'h0a
`define TCCFG_REG_SRESET    8'h10
`define TCCFG_REG_INT_MASK  8'h18
`define TCCFG_REG_INT_STAT  8'h19

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define TCCFG_CTRL_RPSEL    4:3
`define TCCFG_CTRL_ROLE     2:1
`define TCCFG_CTRL_ADMASK   0
`define TCCFG_CTRL_WMASK    8'h1f
`define TCCFG_CTRL_RST      8'h00
`define TCCFG_CONDET_RST    1'h1
`define TCCFG_MASK_RST      5'h1f
`define TCCFG_ZERO8         8'h00

// ****************************************************************
// Encodings
// ****************************************************************
`define TCCFG_ROLE_UFP      2'h0
`define TCCFG_ROLE_DFP      2'h1
`define TCCFG_ROLE_DRP      2'h2
`define TCCFG_TERM_OPEN     2'h0
`define TCCFG_TERM_RA       2'h1
`define TCCFG_TERM_RD       2'h2
`define TCCFG_TERM_RP       2'h3
`define TCCFG_ATT_NONE      3'h0
`define TCCFG_ATT_DFP       3'h1
`define TCCFG_ATT_UFP       3'h2
`define TCCFG_ATT_AUDIO     3'h3
`define TCCFG_ATT_DEBUG     3'h4
`define TCCFG_POL_NONE      2'h0
`define TCCFG_POL_CC1       2'h1
`define TCCFG_POL_CC2       2'h2
`define TCCFG_RP_NONE       2'h0
`define TCCFG_RP_MED        2'h2
`define TCCFG_RP_HIGH       2'h3
`define TCCFG_RPSEL_DFLT    2'h0
`define TCCFG_RPSEL_MED     2'h1
`define TCCFG_RPSEL_HIGH    2'h2
`define TCCFG_VCONN_NONE    2'h0
`define TCCFG_VCONN_CC1     2'h1
`define TCCFG_VCONN_CC2     2'h2
`define TCCFG_I2C_ADDR_TAIL 5'h1d

// ****************************************************************
// Timing
// ****************************************************************
`define TCCFG_LATCH_NS      1000
`define TCCFG_CLK_MHZ       200
`define TCCFG_BIT_ACK       4'h8
`define TCCFG_BIT_POST      4'h9

`endif

// *** tccfg_top.v ***
// Type-C CC controller configuration, strap latch, status and register logic
`timescale 1ns/1ps
`include "tccfg_map.vh"

// What this block does
// RL1 - Decode three-level role strap into DFP/DRP/UFP
// RL2 - Register mode latches role strap once only
// RL3 - Pin mode follows role strap at any time after latch
// RL4 - Address strap high/low selects register mode, bit6
// RL5 - Address strap mid turns bus pins into status
// RL6 - After latch, address pin becomes connection indicator
// RL7 - Connection indicator high while attached, else low
// RL8 - Indicator disable bit resets to one
// RL9 - Interrupt pin open drain, low while pending
// RL10 - Attach, detach, Rp change raise interrupt
// RL11 - Pin mode: third output low on audio accessory
// RL12 - Pin mode UFP: two outputs encode partner Rp
// RL13 - OTG ident low when DFP sees UFP
// RL14 - Chip disable high hibernates, registers lost
// RL15 - DFP advertises software Rp, default after power-up
// RL16 - Rp field selects 80/180/330 uA source
// RL17 - Cable connected bit clears when nothing attached
// RL18 - UFP reports partner current level in status
// RL19 - Straps sampled before bus usable, seed registers
// RL20 - Register mode: pins serve only bus, interrupt
// RL21 - Classify CC terminations, accessories, report status
// RL22 - VCONN status field with interrupt for line
// RL23 - Role field 00 UFP, 01 DFP, 10 DRP overrides
// RL24 - Interrupt releases once unmasked flags read clear
module tccfg_top #(
   parameter integer LATCH_CYC  = (`TCCFG_LATCH_NS * `TCCFG_CLK_MHZ + 999) / 1000,
   parameter [7:0]   REVISION_AND_MAKER_CODE = 8'h5a  // Arbitrary identity value
) (
   input  wire       ref_clk_in,
   input  wire       rst_in,
   input  wire       chip_disable_in,
   input  wire       role_strap_hi_in,
   input  wire       role_strap_lo_in,
   input  wire       adr_strap_hi_in,
   input  wire       adr_strap_lo_in,
   input  wire       scl_in,
   input  wire       sda_in,
   input  wire [1:0] cc1_term_in,
   input  wire [1:0] cc2_term_in,
   input  wire [1:0] partner_rp_in,
   input  wire       vbus_det_in,
   output wire       sda_out,
   output reg        sda_oe_out,
   output wire       scl_out,
   output reg        scl_oe_out,
   output wire       irq_n_out,
   output reg        irq_oe_out,
   output reg        connection_indicator_out,
   output reg        connection_indicator_oe_out,
   output wire       otg_ident_out,
   output reg        otg_ident_oe_out,
   output reg        rp_src_dflt_en_out,
   output reg        rp_src_med_en_out,
   output reg        rp_src_high_en_out,
   output reg  [1:0] cc_role_out
);

   localparam [15:0] LATCH_END = LATCH_CYC[15:0];
   localparam [2:0]  I2C_IDLE  = 3'h0;
   localparam [2:0]  I2C_ADDR  = 3'h1;
   localparam [2:0]  I2C_PTR   = 3'h2;
   localparam [2:0]  I2C_WDATA = 3'h3;
   localparam [2:0]  I2C_RDATA = 3'h4;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg  [15:0] latch_cnt_ff;
   reg         latched_ff;
   reg         reg_mode_ff;
   reg         adr6_ff;
   reg  [7:0]  ctrl_ff;
   reg         condis_ff;
   reg  [4:0]  mask_ff;
   reg  [1:0]  int_ad_ff;
   reg  [4:0]  int_st_ff;
   reg  [2:0]  att_ff;
   reg  [1:0]  pol_ff;
   reg  [1:0]  rpdet_ff;
   reg         vbus_ff;
   reg  [1:0]  vconn_ff;
   reg         srst_ff;
   reg  [2:0]  st_ff;
   reg  [3:0]  bit_ff;
   reg  [7:0]  sh_ff;
   reg  [7:0]  ptr_ff;
   reg         rw_ff;
   reg         drv_ff;
   reg         wr_stb_ff;
   reg  [7:0]  wr_data_ff;
   reg         clr_ad_ff;
   reg         clr_st_ff;
   reg         scl_q_ff;
   reg         sda_q_ff;
   reg  [2:0]  nxt_att;
   reg  [1:0]  nxt_pol;
   reg  [1:0]  nxt_rp;
   reg  [1:0]  nxt_vconn;
   reg  [7:0]  rdata;
   wire        hib;
   wire [1:0]  strap_role;
   wire [1:0]  eff_role;
   wire        act_src;
   wire        irq_pend;
   wire [1:0]  ev_ad;
   wire [4:0]  ev_st;
   wire        scl_rise;
   wire        scl_fall;
   wire        i2c_start;
   wire        i2c_stop;
   wire        bus_on;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function [1:0] role_dec;
      input hi;
      input lo;
      begin
         if (hi)
            role_dec = `TCCFG_ROLE_DFP;  // RL1
         else if (lo)
            role_dec = `TCCFG_ROLE_UFP;  // RL1
         else
            role_dec = `TCCFG_ROLE_DRP;  // RL1
      end
   endfunction

   function is_term;
      input [1:0] line;
      input [1:0] code;
      begin
         is_term = (line == code);
      end
   endfunction

   assign hib        = rst_in | chip_disable_in;  // RL14
   assign strap_role = role_dec(role_strap_hi_in, role_strap_lo_in);
   assign eff_role   = reg_mode_ff ? ctrl_ff[`TCCFG_CTRL_ROLE] : strap_role;  // RL2 RL3 RL23
   assign act_src    = (eff_role == `TCCFG_ROLE_DFP) |
                       ((eff_role == `TCCFG_ROLE_DRP) &
                        (is_term(cc1_term_in, `TCCFG_TERM_RD) |
                         is_term(cc2_term_in, `TCCFG_TERM_RD) |
                         (is_term(cc1_term_in, `TCCFG_TERM_RA) &
                          is_term(cc2_term_in, `TCCFG_TERM_RA))));

   // ****************************************************************
   // Termination classification
   // ****************************************************************
   always @* begin
      nxt_att   = `TCCFG_ATT_NONE;
      nxt_pol   = `TCCFG_POL_NONE;
      nxt_vconn = `TCCFG_VCONN_NONE;
      if (latched_ff & act_src) begin
         if (is_term(cc1_term_in, `TCCFG_TERM_RD) & is_term(cc2_term_in, `TCCFG_TERM_RD)) begin
            nxt_att = `TCCFG_ATT_DEBUG;  // RL21
            nxt_pol = `TCCFG_POL_CC1;
         end else if (is_term(cc1_term_in, `TCCFG_TERM_RA) &
                      is_term(cc2_term_in, `TCCFG_TERM_RA)) begin
            nxt_att = `TCCFG_ATT_AUDIO;  // RL21
            nxt_pol = `TCCFG_POL_CC1;
         end else if (is_term(cc1_term_in, `TCCFG_TERM_RD)) begin
            nxt_att = `TCCFG_ATT_UFP;  // RL21
            nxt_pol = `TCCFG_POL_CC1;
            if (is_term(cc2_term_in, `TCCFG_TERM_RA))
               nxt_vconn = `TCCFG_VCONN_CC2;  // RL22
         end else if (is_term(cc2_term_in, `TCCFG_TERM_RD)) begin
            nxt_att = `TCCFG_ATT_UFP;  // RL21
            nxt_pol = `TCCFG_POL_CC2;
            if (is_term(cc1_term_in, `TCCFG_TERM_RA))
               nxt_vconn = `TCCFG_VCONN_CC1;  // RL22
         end
      end else if (latched_ff) begin
         if (is_term(cc1_term_in, `TCCFG_TERM_RP) & is_term(cc2_term_in, `TCCFG_TERM_RP)) begin
            nxt_att = `TCCFG_ATT_DEBUG;  // RL21
            nxt_pol = `TCCFG_POL_CC1;
         end else if (is_term(cc1_term_in, `TCCFG_TERM_RP)) begin
            nxt_att = `TCCFG_ATT_DFP;  // RL21
            nxt_pol = `TCCFG_POL_CC1;
         end else if (is_term(cc2_term_in, `TCCFG_TERM_RP)) begin
            nxt_att = `TCCFG_ATT_DFP;  // RL21
            nxt_pol = `TCCFG_POL_CC2;
         end
      end
      nxt_rp = (nxt_att == `TCCFG_ATT_DFP) ? partner_rp_in : `TCCFG_RP_NONE;  // RL18
   end

   // Attach/detach and the other change events
   assign ev_ad[0] = (att_ff == `TCCFG_ATT_NONE) & (nxt_att != `TCCFG_ATT_NONE);  // RL10
   assign ev_ad[1] = (att_ff != `TCCFG_ATT_NONE) & (nxt_att == `TCCFG_ATT_NONE);  // RL10
   assign ev_st[4] = (nxt_att == `TCCFG_ATT_DFP) & (nxt_rp != rpdet_ff);  // RL10
   assign ev_st[3] = (nxt_att != att_ff);
   assign ev_st[2] = ((pol_ff == `TCCFG_POL_NONE) & (nxt_pol != `TCCFG_POL_NONE)) |
                     ((nxt_vconn != vconn_ff) & (nxt_vconn != `TCCFG_VCONN_NONE));  // RL22
   assign ev_st[1] = (nxt_att == `TCCFG_ATT_DEBUG) & (att_ff != `TCCFG_ATT_DEBUG);
   assign ev_st[0] = (nxt_att == `TCCFG_ATT_AUDIO) & (att_ff != `TCCFG_ATT_AUDIO);

   assign irq_pend = (|(int_ad_ff & {2{~ctrl_ff[`TCCFG_CTRL_ADMASK]}})) |
                     (|(int_st_ff & ~mask_ff));  // RL24

   // ****************************************************************
   // Strap latch and registers
   // ****************************************************************
   always @(posedge ref_clk_in) begin
      if (hib) begin
         latch_cnt_ff <= 16'h0000;
         latched_ff   <= 1'b0;
         reg_mode_ff  <= 1'b0;
         adr6_ff      <= 1'b0;
      end else if (!latched_ff) begin
         latch_cnt_ff <= latch_cnt_ff + 16'h0001;
         if (latch_cnt_ff == LATCH_END) begin
            latched_ff  <= 1'b1;  // RL19
            reg_mode_ff <= adr_strap_hi_in | adr_strap_lo_in;  // RL4 RL5
            adr6_ff     <= adr_strap_hi_in;  // RL4
         end
      end
   end

   always @(posedge ref_clk_in) begin
      if (hib | srst_ff) begin
         ctrl_ff   <= `TCCFG_CTRL_RST;  // RL15
         condis_ff <= `TCCFG_CONDET_RST;  // RL8
         mask_ff   <= `TCCFG_MASK_RST;
         int_ad_ff <= 2'h0;
         int_st_ff <= 5'h00;
         att_ff    <= `TCCFG_ATT_NONE;
         pol_ff    <= `TCCFG_POL_NONE;
         rpdet_ff  <= `TCCFG_RP_NONE;
         vbus_ff   <= 1'b0;
         vconn_ff  <= `TCCFG_VCONN_NONE;
         srst_ff   <= 1'b0;
      end else begin
         if (!latched_ff)
            ctrl_ff[`TCCFG_CTRL_ROLE] <= strap_role;  // RL2 RL19
         att_ff    <= nxt_att;  // RL17
         pol_ff    <= nxt_pol;
         rpdet_ff  <= nxt_rp;  // RL18
         vbus_ff   <= vbus_det_in & (nxt_att == `TCCFG_ATT_DFP);
         vconn_ff  <= nxt_vconn;  // RL22
         // New event wins over a clear-on-read in the same cycle
         int_ad_ff <= (int_ad_ff & {2{~clr_ad_ff}}) | ev_ad;  // RL10 RL24
         int_st_ff <= (int_st_ff & {5{~clr_st_ff}}) | ev_st;  // RL24
         if (wr_stb_ff) begin
            case (ptr_ff)
               `TCCFG_REG_CTRL:     ctrl_ff   <= wr_data_ff & `TCCFG_CTRL_WMASK;  // RL23 RL15
               `TCCFG_REG_CONDET:   condis_ff <= wr_data_ff[0];
               `TCCFG_REG_INT_MASK: mask_ff   <= wr_data_ff[4:0];
               `TCCFG_REG_SRESET:   srst_ff   <= wr_data_ff[0];
               default:             srst_ff   <= 1'b0;
            endcase
         end
      end
   end

   always @* begin
      case (ptr_ff)
         `TCCFG_REG_VERSION:  rdata = REVISION_AND_MAKER_CODE;
         `TCCFG_REG_CTRL:     rdata = ctrl_ff;
         `TCCFG_REG_INT_AD:   rdata = {6'h00, int_ad_ff};
         `TCCFG_REG_CC_STAT:  rdata = {vbus_ff, rpdet_ff, att_ff, pol_ff};  // RL21 RL18
         `TCCFG_REG_CONDET:   rdata = {7'h00, condis_ff};
         `TCCFG_REG_VCONN:    rdata = {6'h00, vconn_ff};  // RL22
         `TCCFG_REG_INT_MASK: rdata = {3'h0, mask_ff};
         `TCCFG_REG_INT_STAT: rdata = {3'h0, int_st_ff};
         default:             rdata = `TCCFG_ZERO8;
      endcase
   end

   // ****************************************************************
   // Serial register slave
   // ****************************************************************
   assign bus_on    = latched_ff & reg_mode_ff;  // RL19 RL20
   assign scl_rise  = scl_in & ~scl_q_ff;
   assign scl_fall  = ~scl_in & scl_q_ff;
   assign i2c_start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   assign i2c_stop  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;

   always @(posedge ref_clk_in) begin
      if (hib) begin
         st_ff      <= I2C_IDLE;
         bit_ff     <= 4'h0;
         sh_ff      <= 8'h00;
         ptr_ff     <= 8'h00;
         rw_ff      <= 1'b0;
         drv_ff     <= 1'b0;
         wr_stb_ff  <= 1'b0;
         wr_data_ff <= 8'h00;
         clr_ad_ff  <= 1'b0;
         clr_st_ff  <= 1'b0;
         scl_q_ff   <= 1'b1;
         sda_q_ff   <= 1'b1;
      end else begin
         scl_q_ff  <= scl_in;
         sda_q_ff  <= sda_in;
         wr_stb_ff <= 1'b0;
         clr_ad_ff <= 1'b0;
         clr_st_ff <= 1'b0;
         if (!bus_on | i2c_stop) begin
            st_ff  <= I2C_IDLE;
            drv_ff <= 1'b0;
         end else if (i2c_start) begin
            st_ff  <= I2C_ADDR;
            bit_ff <= 4'h0;
            drv_ff <= 1'b0;
         end else if (st_ff == I2C_RDATA) begin
            if (scl_fall & (bit_ff < `TCCFG_BIT_ACK)) begin
               drv_ff <= ~sh_ff[7];
               sh_ff  <= {sh_ff[6:0], 1'b0};
               bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall & (bit_ff == `TCCFG_BIT_ACK)) begin
               drv_ff <= 1'b0;
               bit_ff <= `TCCFG_BIT_POST;
            end else if (scl_rise & (bit_ff == `TCCFG_BIT_POST)) begin
               if (sda_in)
                  st_ff <= I2C_IDLE;
               else
                  bit_ff <= 4'h0;
            end
         end else if (st_ff != I2C_IDLE) begin
            if (scl_rise & (bit_ff < `TCCFG_BIT_ACK)) begin
               sh_ff  <= {sh_ff[6:0], sda_in};
               bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall & (bit_ff == `TCCFG_BIT_ACK)) begin
               bit_ff <= `TCCFG_BIT_POST;
               case (st_ff)
                  I2C_ADDR: begin
                     if (sh_ff[7:1] == {1'b0, adr6_ff, `TCCFG_I2C_ADDR_TAIL}) begin  // RL4
                        drv_ff <= 1'b1;
                        rw_ff  <= sh_ff[0];
                     end else begin
                        st_ff <= I2C_IDLE;
                     end
                  end
                  I2C_PTR: begin
                     drv_ff <= 1'b1;
                     ptr_ff <= sh_ff;
                  end
                  I2C_WDATA: begin
                     drv_ff     <= 1'b1;
                     wr_stb_ff  <= 1'b1;
                     wr_data_ff <= sh_ff;
                  end
                  default: st_ff <= I2C_IDLE;
               endcase
            end else if (scl_fall & (bit_ff == `TCCFG_BIT_POST)) begin
               bit_ff <= 4'h0;
               drv_ff <= 1'b0;
               case (st_ff)
                  I2C_ADDR: begin
                     if (rw_ff) begin
                        st_ff     <= I2C_RDATA;
                        drv_ff    <= ~rdata[7];
                        sh_ff     <= {rdata[6:0], 1'b0};
                        bit_ff    <= 4'h1;
                        clr_ad_ff <= (ptr_ff == `TCCFG_REG_INT_AD);  // RL24
                        clr_st_ff <= (ptr_ff == `TCCFG_REG_INT_STAT);  // RL24
                     end else begin
                        st_ff <= I2C_PTR;
                     end
                  end
                  I2C_PTR:   st_ff <= I2C_WDATA;
                  I2C_WDATA: st_ff <= I2C_WDATA;
                  default:   st_ff <= I2C_IDLE;
               endcase
            end
         end
      end
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   assign sda_out       = 1'b0;
   assign scl_out       = 1'b0;
   assign irq_n_out     = 1'b0;
   assign otg_ident_out = 1'b0;

   always @(posedge ref_clk_in) begin
      if (hib) begin
         sda_oe_out                  <= 1'b0;
         scl_oe_out                  <= 1'b0;
         irq_oe_out                  <= 1'b0;
         connection_indicator_out    <= 1'b0;
         connection_indicator_oe_out <= 1'b0;
         otg_ident_oe_out            <= 1'b0;
         rp_src_dflt_en_out          <= 1'b0;
         rp_src_med_en_out           <= 1'b0;
         rp_src_high_en_out          <= 1'b0;
         cc_role_out                 <= `TCCFG_ROLE_UFP;
      end else if (!latched_ff) begin
         sda_oe_out                  <= 1'b0;
         scl_oe_out                  <= 1'b0;
         irq_oe_out                  <= 1'b0;
         connection_indicator_oe_out <= 1'b0;  // RL6
      end else begin
         if (reg_mode_ff) begin
            sda_oe_out <= drv_ff;  // RL20
            scl_oe_out <= 1'b0;  // RL20
            irq_oe_out <= irq_pend;  // RL9
         end else begin
            sda_oe_out <= (rpdet_ff == `TCCFG_RP_MED) | (rpdet_ff == `TCCFG_RP_HIGH);  // RL12 RL5
            scl_oe_out <= (rpdet_ff == `TCCFG_RP_HIGH);  // RL12 RL5
            irq_oe_out <= (att_ff == `TCCFG_ATT_AUDIO);  // RL11
         end
         connection_indicator_oe_out <= ~reg_mode_ff | ~condis_ff;  // RL6 RL8
         connection_indicator_out    <= (att_ff != `TCCFG_ATT_NONE);  // RL7
         otg_ident_oe_out            <= act_src & (att_ff == `TCCFG_ATT_UFP);  // RL13
         rp_src_dflt_en_out <= act_src &
                               (ctrl_ff[`TCCFG_CTRL_RPSEL] != `TCCFG_RPSEL_MED) &
                               (ctrl_ff[`TCCFG_CTRL_RPSEL] != `TCCFG_RPSEL_HIGH);  // RL16
         rp_src_med_en_out  <= act_src &
                               (ctrl_ff[`TCCFG_CTRL_RPSEL] == `TCCFG_RPSEL_MED);  // RL16
         rp_src_high_en_out <= act_src &
                               (ctrl_ff[`TCCFG_CTRL_RPSEL] == `TCCFG_RPSEL_HIGH);  // RL16
         cc_role_out        <= eff_role;  // RL3
      end
   end

endmodule // tccfg_top

// *** tccfg_checker.sv ***
// Concurrent checks on the ports of the CC configuration block
`timescale 1ns/1ps
module tccfg_checker (
   input wire       ref_clk_in,
   input wire       rst_in,
   input wire       chip_disable_in,
   input wire [1:0] cc1_term_in,
   input wire [1:0] cc2_term_in,
   input wire       sda_out,
   input wire       irq_n_out,
   input wire       irq_oe_out,
   input wire       otg_ident_oe_out,
   input wire       connection_indicator_out,
   input wire       rp_src_dflt_en_out,
   input wire       rp_src_med_en_out,
   input wire       rp_src_high_en_out,
   input wire [1:0] cc_role_out
);
   // ********************
   // Port relations
   // ********************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   wire [2:0] src = {rp_src_dflt_en_out, rp_src_med_en_out, rp_src_high_en_out};
   a_hibernate_quiet: assert property (chip_disable_in |=> !irq_oe_out && !otg_ident_oe_out)
      else $error("pin active in hibernation");
   a_hibernate_role: assert property (chip_disable_in |=> cc_role_out == 2'h0 && src == 3'h0)
      else $error("role or source kept in hibernation");
   a_pins_drive_low: assert property (!sda_out && !irq_n_out)
      else $error("open drain pin driven high");
   a_source_one_hot: assert property ($onehot0(src))
      else $error("more than one current source on");
   a_sink_no_source: assert property (cc_role_out == 2'h0 [*3] |-> src == 3'h0)
      else $error("current source on in sink role");
   a_role_code_legal: assert property (cc_role_out != 2'h3)
      else $error("reserved role code");
   a_open_no_connect: assert property (
      (cc1_term_in == 2'h0 && cc2_term_in == 2'h0) [*3] |=> !connection_indicator_out)
      else $error("connection shown with both lines open");
   a_ident_needs_sink: assert property (otg_ident_oe_out |->
      $past(cc1_term_in, 2) == 2'h2 || $past(cc2_term_in, 2) == 2'h2)
      else $error("ident pulled low without a sink");
   cover property (irq_oe_out);
   cover property (otg_ident_oe_out);
   cover property (src == 3'h1);
endmodule // tccfg_checker
bind tccfg_top tccfg_checker tccfg_checker_i (.ref_clk_in, .rst_in, .chip_disable_in,
   .cc1_term_in, .cc2_term_in, .sda_out, .irq_n_out, .irq_oe_out, .otg_ident_oe_out,
   .connection_indicator_out, .rp_src_dflt_en_out, .rp_src_med_en_out,
   .rp_src_high_en_out, .cc_role_out);

// *** tccfg_partner.sv ***
// Remote port partner showing terminations on the CC lines
`timescale 1ns/1ps
module tccfg_partner (
   input  wire [1:0] kind_in,
   input  wire [1:0] level_in,
   output wire [1:0] cc1_term_out,
   output wire [1:0] cc2_term_out,
   output wire [1:0] rp_out,
   output wire       vbus_out
);
   // ********************
   // Terminations
   // ********************
   // Kind 1 sink shows Rd, 2 source shows Rp, 3 audio plug shows Ra twice
   assign cc1_term_out = (kind_in == 2'h3) ? 2'h1 : (kind_in == 2'h1) ? 2'h2
                       : (kind_in == 2'h2) ? 2'h3 : 2'h0;
   assign cc2_term_out = (kind_in == 2'h3) ? 2'h1 : 2'h0;
   assign rp_out       = (kind_in == 2'h2) ? level_in : 2'h0;
   assign vbus_out     = (kind_in == 2'h2);
endmodule // tccfg_partner

// *** testbench.sv ***
// Self-checking testbench for the CC configuration block
`timescale 1ns/1ps
module testbench;
   localparam [7:0] VER = 8'hc3;  // Arbitrary identity value
   reg        clk = 1'b0, rst = 1'b1, dis = 1'b0, scl_d = 1'b1, sda_d = 1'b1;
   reg  [3:0] strap = 4'h0;
   reg  [1:0] kind = 2'h0, lvl = 2'h1;
   reg  [7:0] dev = 8'h7a, v;
   integer    miscompares = 0, comparisons = 0, i;
   wire [1:0] cc1, cc2, rp, role;
   wire [2:0] rs;
   wire       vbus, sda_oe, scl_oe, irq_oe, ci, ci_oe, id_oe;
   wire       sda_w = sda_d & ~sda_oe;
   always #2.5 clk = ~clk;
   tccfg_partner tccfg_partner_i (.kind_in(kind), .level_in(lvl), .cc1_term_out(cc1),
      .cc2_term_out(cc2), .rp_out(rp), .vbus_out(vbus));
   tccfg_top #(.LATCH_CYC(4), .REVISION_AND_MAKER_CODE(VER)) tccfg_top_i (.ref_clk_in(clk), .rst_in(rst),
      .chip_disable_in(dis), .role_strap_hi_in(strap[1]), .role_strap_lo_in(strap[0]),
      .adr_strap_hi_in(strap[3]), .adr_strap_lo_in(strap[2]), .scl_in(scl_d & ~scl_oe),
      .sda_in(sda_w), .cc1_term_in(cc1), .cc2_term_in(cc2), .partner_rp_in(rp),
      .vbus_det_in(vbus), .sda_out(), .sda_oe_out(sda_oe), .scl_out(), .scl_oe_out(scl_oe),
      .irq_n_out(), .irq_oe_out(irq_oe), .connection_indicator_out(ci),
      .connection_indicator_oe_out(ci_oe), .otg_ident_out(), .otg_ident_oe_out(id_oe),
      .rp_src_dflt_en_out(rs[2]), .rp_src_med_en_out(rs[1]), .rp_src_high_en_out(rs[0]),
      .cc_role_out(role));
   // ********************
   // Helpers
   // ********************
   task check(input [15:0] seen, input [15:0] exp, input [95:0] what);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task final_report;
      begin
         if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task drive(input c, input d);
      begin
         @(posedge clk);
         scl_d <= c;
         sda_d <= d;
         tick(4);
      end
   endtask
   // Start when s is 1, stop when s is 0
   task frame(input s);
      begin
         drive(s, s);
         drive(1'b1, 1'b0);
         drive(!s, !s);
      end
   endtask
   task xfer(input [8:0] d, output [8:0] r);
      integer k;
      begin
         for (k = 8; k >= 0; k = k - 1) begin
            drive(1'b0, d[k]);
            drive(1'b1, d[k]);
            r[k] = sda_w;
            drive(1'b0, d[k]);
         end
      end
   endtask
   task acc(input w, input [7:0] p, input [7:0] d);
      reg [8:0] r1, r2, r3, r4;
      begin
         frame(1'b1);
         xfer({dev, 1'b1}, r1);
         xfer({p, 1'b1}, r2);
         if (w) begin
            xfer({d, 1'b1}, r3);
         end else begin
            frame(1'b0);
            frame(1'b1);
            xfer({dev | 8'h01, 1'b1}, r3);
            xfer(9'h1ff, r4);
            v = r4[8:1];
         end
         frame(1'b0);
         check({r1[0], r2[0], r3[0]}, 16'h0, "ack");
      end
   endtask
   task powerup(input [3:0] s);
      begin
         @(posedge clk);
         rst <= 1'b1;
         strap <= s;
         kind <= 2'h0;
         tick(2);
         rst <= 1'b0;
         tick(8);
      end
   endtask
   // ********************
   // Scenarios
   // ********************
   task pin_test;
      begin
         powerup(4'h2);
         kind <= 2'h1;
         tick(6);
         check({ci_oe, ci, id_oe, role}, 16'h1d, "pin");
         check(rs, 16'h4, "rp_src");
         kind <= 2'h3;
         tick(6);
         check(irq_oe, 16'h1, "audio");
         kind <= 2'h0;
         strap <= 4'h0;
         tick(6);
         check({irq_oe, ci, role}, 16'h2, "idle");
         strap <= 4'h1;
         kind <= 2'h2;
         for (i = 1; i < 4; i = i + 1) begin
            lvl <= i[1:0];
            tick(6);
            check({scl_oe, sda_oe}, (16'h1 << (i - 1)) - 16'h1, "status");
         end
      end
   endtask
   task reg_test;
      begin
         powerup(4'h9);
         check(ci_oe, 16'h0, "ci_oe");
         acc(1'b1, 8'h01, 8'h00);
         acc(1'b0, 8'h01, 8'h00);
         check(v, VER, "version");
         acc(1'b0, 8'h02, 8'h00);
         check(v, 16'h0, "ctrl");
         strap <= 4'ha;
         tick(6);
         check(role, 16'h0, "role");
         for (i = 0; i < 3; i = i + 1) begin
            acc(1'b1, 8'h02, {3'h0, i[1:0], 3'h2});
            acc(1'b0, 8'h02, 8'h00);
            check({role, rs, v}, {2'h1, 3'h4 >> i, 3'h0, i[1:0], 3'h2}, "ctrl");
         end
         kind <= 2'h1;
         tick(6);
         check(irq_oe, 16'h1, "irq");
         acc(1'b0, 8'h03, 8'h00);
         check({irq_oe, v}, 16'h1, "int_ad");
         acc(1'b1, 8'h09, 8'h00);
         check({ci_oe, ci}, 16'h3, "ci");
         kind <= 2'h0;
         tick(6);
         acc(1'b0, 8'h04, 8'h00);
         check(v, 16'h0, "cc_stat");
         acc(1'b0, 8'h05, 8'h00);
         check(v, 16'h0, "unmapped");
         dis <= 1'b1;
         tick(2);
         check({ci_oe, role}, 16'h0, "hibernate");
         dis <= 1'b0;
         tick(8);
         acc(1'b0, 8'h02, 8'h00);
         check(v, 16'h2, "ctrl");
      end
   endtask
   task low_test;
      reg [8:0] r;
      begin
         powerup(4'h4);
         frame(1'b1);
         xfer({dev, 1'b1}, r);
         frame(1'b0);
         check(r[0], 16'h1, "nack");
         dev = 8'h3a;
         acc(1'b0, 8'h02, 8'h00);
         check(v, 16'h4, "ctrl");
         acc(1'b1, 8'h02, 8'h00);
         kind <= 2'h2;
         lvl <= 2'h3;
         tick(6);
         check({scl_oe, role}, 16'h0, "status");
      end
   endtask
   initial begin
      pin_test;
      reg_test;
      low_test;
      final_report;
   end
   initial begin
      #300000;
      miscompares = miscompares + 1;
      final_report;
   end
endmodule // testbench
